//--- hw/pwm_tb_pkg.sv
package pwm_tb_pkg;

    // Register byte addresses on the AHB-Lite bus
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNT   = 8'h04;
    localparam logic [7:0] ADDR_PERIOD  = 8'h08;
    localparam logic [7:0] ADDR_DUTY0   = 8'h0C;
    localparam logic [7:0] ADDR_DUTY1   = 8'h10;
    localparam logic [7:0] ADDR_DUTY2   = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_MASK    = 8'h1C;

    // Control register field positions
    localparam int CTL_RUN_BIT = 15;
    localparam int CTL_OPS_LSB = 4;
    localparam int CTL_PS_LSB  = 2;
    localparam int CTL_MOD_LSB = 0;

    // Widths and the direction bit position
    localparam int CNT_W   = 15;
    localparam int N_PWM   = 3;
    localparam int N_EVT   = 2;
    localparam int DIR_BIT = 15;

    // Status bits
    localparam int EVT_TB     = 0;
    localparam int EVT_SINGLE = 1;

    // Reset and step values
    localparam logic [CNT_W-1:0] CNT_ZERO  = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 15'h0001;
    localparam logic [3:0]       POST_ZERO = 4'h0;
    localparam logic [5:0]       PRE_ZERO  = 6'h00;
    localparam logic [5:0]       PRE_ONE   = 6'h01;

    // Mode field encodings
    typedef enum logic [1:0] {
        MODE_FREE   = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_UPDN   = 2'h2,
        MODE_UPDN2  = 2'h3
    } tb_mode_e;

endpackage

//--- hw/pwm_time_base_and_compare.sv
// How it works
// - 15-bit counter, prescaler, postscaled interrupt events
// - Count bit 15 is read-only down flag
// - Run bit starts/stops; stopping keeps count
// - Period match resets or reverses next clock
// - Zero period: halt, no events, freeze period while running
// - Two-bit mode: free, single, updown, updown-double
// - Free-running wraps on match, postscaled event
// - Single-shot: match resets, clears run, one event
// - Up/down reverses at period, flag set descending
// - Up/down event at zero turnaround, postscaled
// - Events depend on mode and postscale field
// - Edge-aligned: active at zero, off at duty match
// - Edge duty zero off, above period on
// - Center: on at down match, off up match
// - Center duty zero off, equal period on
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module pwm_time_base_and_compare
    import pwm_tb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // PWM outputs and interrupt
    output logic [N_PWM-1:0] pwm_out,
    output logic             irq
);

    typedef struct packed {
        logic                       run;
        tb_mode_e                   mode;
        logic [3:0]                 ops;
        logic [1:0]                 ps;
        logic [CNT_W-1:0]           count;
        logic                       down;
        logic [CNT_W-1:0]           period;
        logic [N_PWM-1:0][CNT_W-1:0] duty;
        logic [5:0]                 pre_cnt;
        logic [3:0]                 post_cnt;
        logic [N_PWM-1:0]           pwm;
        logic [N_EVT-1:0]           status;
        logic [N_EVT-1:0]           mask;
        logic                       wr_pend;
        logic                       rd_pend;
        logic [7:0]                 addr;
        logic [31:0]                rdata;
    } state_s;

    state_s st_q;
    state_s st_d;

    // Prescale divide ratio: 1, 4, 16, 64 input clocks
    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_limit = 6'h00;
            2'h1:    pre_limit = 6'h03;
            2'h2:    pre_limit = 6'h0F;
            default: pre_limit = 6'h3F;
        endcase
    endfunction

    // Register read mux
    function automatic logic [31:0] read_reg(input state_s s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == ADDR_CONTROL) begin
            r[CTL_RUN_BIT] = s.run;
            r[CTL_OPS_LSB +: 4] = s.ops;
            r[CTL_PS_LSB +: 2] = s.ps;
            r[CTL_MOD_LSB +: 2] = s.mode;
        end else if (a == ADDR_COUNT) begin
            r[CNT_W-1:0] = s.count;
            r[DIR_BIT] = s.down;
        end else if (a == ADDR_PERIOD) begin
            r[CNT_W-1:0] = s.period;
        end else if (a == ADDR_DUTY0) begin
            r[CNT_W-1:0] = s.duty[0];
        end else if (a == ADDR_DUTY1) begin
            r[CNT_W-1:0] = s.duty[1];
        end else if (a == ADDR_DUTY2) begin
            r[CNT_W-1:0] = s.duty[2];
        end else if (a == ADDR_STATUS) begin
            r[N_EVT-1:0] = s.status;
        end else if (a == ADDR_MASK) begin
            r[N_EVT-1:0] = s.mask;
        end
        read_reg = r;
    endfunction

    logic             tick;
    logic             match;
    logic             at_zero;
    logic             updn;
    logic             raw_evt;
    logic             tb_evt;
    logic             single_evt;
    logic [N_EVT-1:0] evt;

    // Next-state logic
    always_comb begin
        st_d = st_q;
        updn = (st_q.mode == MODE_UPDN) || (st_q.mode == MODE_UPDN2);
        // Zero period holds the counter still
        tick = st_q.run && (st_q.period != CNT_ZERO)
               && (st_q.pre_cnt >= pre_limit(st_q.ps));
        match = (st_q.count == st_q.period);
        at_zero = st_q.down && (st_q.count == CNT_ONE);
        raw_evt = 1'b0;
        single_evt = 1'b0;

        // Prescaler wraps on its own, even with a zero period; a stale
        // count above a newly lowered limit must not stall the ticks
        if (st_q.run) begin
            if (st_q.pre_cnt >= pre_limit(st_q.ps)) begin
                st_d.pre_cnt = PRE_ZERO;
            end else begin
                st_d.pre_cnt = st_q.pre_cnt + PRE_ONE;
            end
        end

        // Counter step for each mode
        if (tick) begin
            case (st_q.mode)
                MODE_FREE: begin
                    if (match) begin
                        st_d.count = CNT_ZERO;
                        raw_evt = 1'b1;
                    end else begin
                        st_d.count = st_q.count + CNT_ONE;
                    end
                end
                MODE_SINGLE: begin
                    if (match) begin
                        st_d.count = CNT_ZERO;
                        st_d.run = 1'b0;
                        single_evt = 1'b1;
                    end else begin
                        st_d.count = st_q.count + CNT_ONE;
                    end
                end
                default: begin
                    if (!st_q.down && match) begin
                        st_d.down = 1'b1;
                        st_d.count = st_q.count - CNT_ONE;
                        raw_evt = (st_q.mode == MODE_UPDN2);
                    end else if (st_q.down && (at_zero || st_q.count == CNT_ZERO)) begin
                        st_d.down = 1'b0;
                        st_d.count = CNT_ZERO;
                        raw_evt = 1'b1;
                    end else if (st_q.down) begin
                        st_d.count = st_q.count - CNT_ONE;
                    end else begin
                        st_d.count = st_q.count + CNT_ONE;
                    end
                end
            endcase
        end
        // Up-only modes never report a descent
        if (!updn) begin
            st_d.down = 1'b0;
        end

        // Postscaler thins events; at or above the select so a lowered ratio acts at once
        tb_evt = 1'b0;
        if (raw_evt) begin
            if (st_q.post_cnt >= st_q.ops) begin
                st_d.post_cnt = POST_ZERO;
                tb_evt = 1'b1;
            end else begin
                st_d.post_cnt = st_q.post_cnt + 4'h1;
            end
        end
        evt = {single_evt, tb_evt};

        // PWM outputs, compared on the counter being entered
        for (int i = 0; i < N_PWM; i++) begin
            if (st_q.duty[i] == CNT_ZERO) begin
                st_d.pwm[i] = 1'b0;
            end else if (!updn) begin
                if (st_q.duty[i] > st_q.period) begin
                    st_d.pwm[i] = 1'b1;
                end else if (st_d.count == st_q.duty[i]) begin
                    st_d.pwm[i] = 1'b0;
                end else if (st_d.count == CNT_ZERO) begin
                    st_d.pwm[i] = 1'b1;
                end
            end else begin
                if (st_q.duty[i] == st_q.period) begin
                    st_d.pwm[i] = 1'b1;
                end else if (st_d.count == st_q.duty[i]) begin
                    st_d.pwm[i] = st_d.down;
                end
            end
        end

        // AHB-Lite address phase capture
        st_d.wr_pend = 1'b0;
        st_d.rd_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_d.wr_pend = hwrite;
            st_d.rd_pend = !hwrite;
            st_d.addr = haddr;
            st_d.rdata = read_reg(st_q, haddr);
        end

        // Data phase write, hardware event beats clear
        st_d.status = st_q.status;
        if (st_q.wr_pend) begin
            if (st_q.addr == ADDR_CONTROL) begin
                st_d.run = hwdata[CTL_RUN_BIT];
                st_d.ops = hwdata[CTL_OPS_LSB +: 4];
                st_d.ps = hwdata[CTL_PS_LSB +: 2];
                st_d.mode = tb_mode_e'(hwdata[CTL_MOD_LSB +: 2]);
            end else if (st_q.addr == ADDR_PERIOD) begin
                // A running zero period is locked
                if (!(st_q.run && st_q.period == CNT_ZERO)) begin
                    st_d.period = hwdata[CNT_W-1:0];
                end
            end else if (st_q.addr == ADDR_DUTY0) begin
                st_d.duty[0] = hwdata[CNT_W-1:0];
            end else if (st_q.addr == ADDR_DUTY1) begin
                st_d.duty[1] = hwdata[CNT_W-1:0];
            end else if (st_q.addr == ADDR_DUTY2) begin
                st_d.duty[2] = hwdata[CNT_W-1:0];
            end else if (st_q.addr == ADDR_STATUS) begin
                st_d.status = st_q.status & ~hwdata[N_EVT-1:0];
            end else if (st_q.addr == ADDR_MASK) begin
                st_d.mask = hwdata[N_EVT-1:0];
            end
            // Count register is read-only
        end
        st_d.status = st_d.status | evt;
        // Hardware halt wins over a same-cycle run write
        if (single_evt) begin
            st_d.run = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs; zero-wait slave
    assign hrdata    = st_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pwm_out   = st_q.pwm;
    assign irq       = |(st_q.status & st_q.mask);

    // Stopping keeps the count
    a_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
        (!st_q.run && !$past(st_q.wr_pend)) |=> (st_q.count == $past(st_q.count)))
        else $error("count moved while stopped");

    a_zero_period: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.period == CNT_ZERO) |=> !st_q.status[EVT_TB] || $past(st_q.status[EVT_TB]))
        else $error("event with zero period");

    a_free_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_FREE && match) |=> (st_q.count == CNT_ZERO))
        else $error("free mode did not wrap");

    a_single_stop: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_SINGLE && match)
        |=> (!st_q.run && st_q.count == CNT_ZERO && st_q.status[EVT_SINGLE]))
        else $error("single shot did not halt");

    a_updn_turn: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && updn && !st_q.down && match) |=> st_q.down)
        else $error("no reversal at period");

    a_updn_event: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && updn && st_q.down && at_zero) |=> (!st_q.down && st_q.count == CNT_ZERO))
        else $error("no turn at zero");

    a_edge_full: assert property (@(posedge clk) disable iff (!rst_b)
        (!updn && st_q.duty[0] != CNT_ZERO && st_q.duty[0] > st_q.period) |=> pwm_out[0])
        else $error("edge output not full on");

    a_duty_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.duty[1] == CNT_ZERO) |=> !pwm_out[1])
        else $error("zero duty not off");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.status[EVT_TB] && st_q.mask[EVT_TB]) |-> irq)
        else $error("irq missing");

    // Prescaled tick leaves a gap behind it
    a_pre_gap: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.ps != 2'h0 && !st_q.wr_pend) |=> !tick)
        else $error("prescaler did not divide");

    // Direction flag read back with the count
    a_dir_read: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.rd_pend && st_q.addr == ADDR_COUNT) |-> (hrdata[DIR_BIT] == $past(st_q.down)))
        else $error("direction flag not read back");

    // Up-only modes show no down flag
    a_dir_up: assert property (@(posedge clk) disable iff (!rst_b)
        (!updn) |=> !st_q.down)
        else $error("down flag in up-only mode");

    // Run bit follows a control write
    a_run_write: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.wr_pend && st_q.addr == ADDR_CONTROL && !single_evt) |=> (st_q.run == $past(hwdata[CTL_RUN_BIT])))
        else $error("run bit not written");

    // Reversal steps one below the period
    a_turn_step: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && updn && !st_q.down && match) |=> (st_q.count == $past(st_q.count) - CNT_ONE))
        else $error("no step after period match");

    // Zero period stays locked while running
    a_period_lock: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.run && st_q.period == CNT_ZERO) |=> (st_q.period == CNT_ZERO))
        else $error("zero period changed while running");

    // Mode field follows a control write
    a_mode_write: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.wr_pend && st_q.addr == ADDR_CONTROL) |=> (st_q.mode == $past(hwdata[CTL_MOD_LSB +: 2])))
        else $error("mode not written");

    // Free-running match raises the event when due
    a_free_event: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_FREE && match && st_q.post_cnt >= st_q.ops) |=> st_q.status[EVT_TB])
        else $error("free mode event missing");

    // Single shot leaves the postscaler alone
    a_single_post: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q.mode == MODE_SINGLE) |=> (st_q.post_cnt == $past(st_q.post_cnt)))
        else $error("single shot moved postscaler");

    // Descent steps down by one with the flag set
    a_down_step: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && updn && st_q.down && !at_zero && st_q.count != CNT_ZERO)
        |=> (st_q.down && st_q.count == $past(st_q.count) - CNT_ONE))
        else $error("descent step wrong");

    // Plain up/down mode is quiet at the period
    a_updn_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_UPDN && !st_q.down && match) |-> !raw_evt)
        else $error("event at period in plain up/down");

    // Thinned events leave the flag alone
    a_post_thin: assert property (@(posedge clk) disable iff (!rst_b)
        (raw_evt && st_q.post_cnt < st_q.ops) |=> (!st_q.status[EVT_TB] || $past(st_q.status[EVT_TB])))
        else $error("postscaler let event through");

    // Edge output rises as the count wraps
    a_edge_rise: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_FREE && match && st_q.duty[2] != CNT_ZERO) |=> pwm_out[2])
        else $error("edge output did not rise");

    // Edge output falls on its duty match
    a_edge_fall: assert property (@(posedge clk) disable iff (!rst_b)
        (!updn && st_q.duty[2] != CNT_ZERO && st_q.duty[2] <= st_q.period
         && st_d.count == st_q.duty[2]) |=> !pwm_out[2])
        else $error("edge output did not fall");

    // Center output on descending, off ascending
    a_center_on: assert property (@(posedge clk) disable iff (!rst_b)
        (updn && st_q.duty[2] != CNT_ZERO && st_q.duty[2] != st_q.period
         && st_d.count == st_q.duty[2]) |=> (pwm_out[2] == $past(st_d.down)))
        else $error("center output wrong at match");

    // Center output full on at a period duty
    a_center_full: assert property (@(posedge clk) disable iff (!rst_b)
        (updn && st_q.duty[1] != CNT_ZERO && st_q.duty[1] == st_q.period) |=> pwm_out[1])
        else $error("center output not full on");

    // Double-update mode also fires at the period
    a_double_evt: assert property (@(posedge clk) disable iff (!rst_b)
        (tick && st_q.mode == MODE_UPDN2 && !st_q.down && match) |-> raw_evt)
        else $error("no event at period in double mode");

endmodule

//--- tb/pwm_power_stage.sv
`timescale 1ns/1ps
// Power stage stand-in: counts the cycles each gate input is driven on
module pwm_power_stage
    import pwm_tb_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Gate drive and observation window
    input  wire logic [N_PWM-1:0] gate,
    input  wire logic             clr,
    input  wire logic             watch,
    output logic [7:0]            on_cnt [N_PWM]
);
    // Counts only inside the window, so each measurement stands alone
    always_ff @(posedge clk or negedge rst_b) begin
        for (int i = 0; i < N_PWM; i++) begin
            if (!rst_b || clr) begin
                on_cnt[i] <= 8'h00;
            end else if (watch && gate[i]) begin
                on_cnt[i] <= on_cnt[i] + 8'h01;
            end
        end
    end
endmodule

//--- tb/pwm_time_base_and_compare_test.sv
`timescale 1ns/1ps
module pwm_time_base_and_compare_test
    import pwm_tb_pkg::*;
;
    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, clr, watch;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r, held;
    logic [N_PWM-1:0] pwm_out;
    logic [7:0]  on_cnt [N_PWM];
    int          error_cnt, n_tests;

    pwm_time_base_and_compare pwm_time_base_and_compare_i (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pwm_out(pwm_out), .irq(irq));
    pwm_power_stage pwm_power_stage_i (
        .clk(clk), .rst_b(rst_b), .gate(pwm_out), .clr(clr), .watch(watch), .on_cnt(on_cnt));

    // Clock of 100 ns period
    always #50 clk = ~clk;

    task automatic close_out();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    // Polls a bit with a bounded number of reads; r keeps the last value
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        for (int i = 0; i < 100; i++) begin
            rd(a);
            if (r[b] === v) break;
        end
    endtask

    // Power stage measurement over 40 cycles: eight periods of five, two of twenty prescaled, or five up/down periods of eight
    task automatic measure();
        clr <= 1'b1;
        @(posedge clk);
        clr   <= 1'b0;
        watch <= 1'b1;
        repeat (40) @(posedge clk);
        watch <= 1'b0;
        @(posedge clk);
    endtask

    // Watchdog: the sequence needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end

    initial begin
        clk = 1'b0; rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00; htrans = 2'h0;
        hsize = 3'h2; hwdata = 32'h0000_0000; clr = 1'b0; watch = 1'b0;
        error_cnt = 0; n_tests = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // Reset state and an unmapped place
        rd(ADDR_CONTROL); chk(r, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        rd(ADDR_PERIOD);  chk(r, 32'h0000_0000);
        rd(8'h40);        chk(r, 32'h0000_0000);
        // Zero period: halted, no event, period update refused while running
        xfer(1'b1, ADDR_CONTROL, 32'h0000_8000);
        repeat (20) @(posedge clk);
        rd(ADDR_COUNT);  chk(r, 32'h0000_0000);
        rd(ADDR_STATUS); chk(r, 32'h0000_0000);
        xfer(1'b1, ADDR_PERIOD, 32'h0000_0004);
        rd(ADDR_PERIOD); chk(r, 32'h0000_0000);
        // Software stops the time base before fixing the period
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0000);
        xfer(1'b1, ADDR_PERIOD, 32'h0000_0004);
        rd(ADDR_PERIOD); chk(r, 32'h0000_0004);
        rd(ADDR_COUNT);  chk(r, 32'h0000_0000);
        // Edge-aligned duties: off, above period, mid
        xfer(1'b1, ADDR_DUTY0, 32'h0000_0000);
        xfer(1'b1, ADDR_DUTY1, 32'h0000_0005);
        xfer(1'b1, ADDR_DUTY2, 32'h0000_0002);
        xfer(1'b1, ADDR_CONTROL, 32'h0000_8000);
        repeat (12) @(posedge clk);
        measure();
        chk({24'h0, on_cnt[0]}, 32'h0000_0000);
        chk({24'h0, on_cnt[1]}, 32'h0000_0028);
        chk({24'h0, on_cnt[2]}, 32'h0000_0010);
        rd(ADDR_COUNT);  chk({r[31:3] == 29'h0, 2'b00}, {1'b1, 2'b00});
        rd(ADDR_STATUS); chk(r, 32'h0000_0001);
        // Interrupt: unmasked raises, masked drops
        // Mask lands on the last edge of the write; irq is looked at one edge later
        xfer(1'b1, ADDR_MASK, 32'h0000_0001);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        xfer(1'b1, ADDR_MASK, 32'h0000_0000);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        // Prescale by four: five states of four cycles, two of them on
        xfer(1'b1, ADDR_CONTROL, 32'h0000_8004);
        repeat (40) @(posedge clk);
        measure();
        chk({24'h0, on_cnt[2]}, 32'h0000_0010);
        // One event in four matches: none within 12 cycles of the last
        xfer(1'b1, ADDR_CONTROL, 32'h0000_8030);
        xfer(1'b1, ADDR_STATUS, 32'h0000_0001);
        wait_bit(ADDR_STATUS, EVT_TB, 1'b1);
        xfer(1'b1, ADDR_STATUS, 32'h0000_0001);
        repeat (8) @(posedge clk);
        rd(ADDR_STATUS); chk(r, 32'h0000_0000);
        // Stopping keeps the count
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0000);
        rd(ADDR_COUNT);
        held = r;
        repeat (10) @(posedge clk);
        rd(ADDR_COUNT); chk(r, held);
        xfer(1'b1, ADDR_STATUS, 32'h0000_0003);
        rd(ADDR_STATUS); chk(r, 32'h0000_0000);
        // Single shot clears its own run bit and flags its own event
        xfer(1'b1, ADDR_CONTROL, 32'h0000_80F1);
        wait_bit(ADDR_CONTROL, CTL_RUN_BIT, 1'b0); chk(r, 32'h0000_00F1);
        rd(ADDR_STATUS); chk({31'h0, r[EVT_SINGLE]}, 32'h0000_0001);
        rd(ADDR_COUNT);  chk(r, 32'h0000_0000);
        // Up/down modes: direction flag, turnaround event, center duties
        xfer(1'b1, ADDR_STATUS, 32'h0000_0003);
        xfer(1'b1, ADDR_DUTY1, 32'h0000_0004);
        for (int m = 2; m < 4; m++) begin
            xfer(1'b1, ADDR_CONTROL, 32'h0000_8000 | m);
            wait_bit(ADDR_COUNT, DIR_BIT, 1'b1);
            chk({31'h0, r[14:0] <= 15'h0004 && r[14:0] != 15'h0000}, 32'h0000_0001);
            wait_bit(ADDR_STATUS, EVT_TB, 1'b1); chk(r, 32'h0000_0001);
            measure();
            chk({24'h0, on_cnt[0]}, 32'h0000_0000);
            chk({24'h0, on_cnt[1]}, 32'h0000_0028);
            chk({24'h0, on_cnt[2]}, 32'h0000_0014);
            xfer(1'b1, ADDR_CONTROL, 32'h0000_0000);
            xfer(1'b1, ADDR_STATUS, 32'h0000_0003);
        end
        close_out();
    end
endmodule
